// File: common/sss_cfg.svh
// Timing constants for the supply switch sequencer
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH
`define SSS_CLK_MHZ        50
`define SSS_STEP_US        250
`define SSS_STEP_CYC       (`SSS_STEP_US * `SSS_CLK_MHZ)
`define SSS_NUM_STEPS      4
`define SSS_DETECT_US      20
`define SSS_DETECT_CYC     (`SSS_DETECT_US * `SSS_CLK_MHZ)
`define SSS_SWITCHOVER_US  26
`define SSS_SWITCHOVER_CYC (`SSS_SWITCHOVER_US * `SSS_CLK_MHZ)
`endif

// File: common/sss_pkg.sv
// Types for the supply switch sequencer
package sss_pkg;
    typedef enum logic [2:0] {
        SSS_OFF     = 3'h0,
        SSS_PRIMARY = 3'h1,
        SSS_DETECT  = 3'h2,
        SSS_DRAIN   = 3'h3,
        SSS_SECOND  = 3'h4,
        SSS_OPEN    = 3'h5
    } sss_state_t;
endpackage : sss_pkg

// File: common/sss_ramp_if.sv
// Soft start request and step level between top and ramp
`timescale 1ns/1ps
`default_nettype none
interface sss_ramp_if;
    logic       start;
    logic       active;
    logic [2:0] step;
    modport ctl  (output start, input active, input step);
    modport ramp (input start, output active, output step);
endinterface : sss_ramp_if
`default_nettype wire

// File: logic/sss_ramp.sv
// Stepped soft start timer for the pass switches
`timescale 1ns/1ps
`default_nettype none
`include "sss_cfg.svh"
module sss_ramp
    import sss_pkg::*;
#(
    parameter int STEP_CYC = `SSS_STEP_CYC
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic nrst_i,
    input  wire logic ce_i,
    // Control
    sss_ramp_if.ramp  rif
);
    typedef struct packed {
        logic [31:0] cnt;
        logic [2:0]  step;
    } sss_ramp_st_t;

    sss_ramp_st_t st_ff;
    sss_ramp_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (rif.start) begin
            nxt_st.step = 3'h0;
            nxt_st.cnt  = 32'h0;
        end else if (st_ff.step != 3'(`SSS_NUM_STEPS)) begin
            if (st_ff.cnt == 32'(STEP_CYC - 1)) begin
                nxt_st.cnt  = 32'h0;
                nxt_st.step = st_ff.step + 3'h1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            st_ff <= '{cnt: 32'h0, step: 3'(`SSS_NUM_STEPS)};
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    assign rif.step   = st_ff.step;
    assign rif.active = st_ff.step != 3'(`SSS_NUM_STEPS);

    step_bound_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        st_ff.step <= 3'(`SSS_NUM_STEPS))
        else $error("ramp step out of range");
endmodule : sss_ramp
`default_nettype wire

// File: logic/sss_top.sv
// Supply selection sequencer with soft start and UART buffers
`timescale 1ns/1ps
`default_nettype none
`include "sss_cfg.svh"
module sss_top
    import sss_pkg::*;
#(
    parameter int STEP_CYC   = `SSS_STEP_CYC,
    parameter int DETECT_CYC = `SSS_DETECT_CYC,
    parameter int SWITCH_CYC = `SSS_SWITCHOVER_CYC
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    // Supply monitors
    input  wire logic       first_valid_i,
    input  wire logic       first_high_i,
    input  wire logic       second_valid_i,
    input  wire logic       thermal_shutdown_i,
    input  wire logic       secondary_enable_i,
    // Pass switches
    output logic            primary_pass_switches_o,
    output logic            second_pass_switches_o,
    output logic            primary_output_on_o,
    output logic            secondary_output_on_o,
    output logic [2:0]      soft_step_o,
    output logic            output_valid_n_indicator_o,
    // UART buffers
    input  wire logic       output_enable_i,
    input  wire logic       cable_transmit_in_i,
    input  wire logic       host_receive_in_i,
    output logic            host_transmit_out_o,
    output logic            host_transmit_out_oe_o,
    output logic            cable_receive_out_o
);
    typedef struct packed {
        sss_state_t  state;
        logic [31:0] cnt;
        logic        prim_on;
        logic        sec_on;
        logic        valid;
        logic        tx;
        logic        tx_oe;
        logic        rx;
    } sss_top_st_t;

    sss_top_st_t st_ff;
    sss_top_st_t nxt_st;
    sss_ramp_if  rif ();
    logic        fault;
    logic        sel_second;

    sss_ramp #(
        .STEP_CYC (STEP_CYC)
    ) u_ramp (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .rif     (rif)
    );

    assign fault = thermal_shutdown_i;

    always_comb begin
        nxt_st    = st_ff;
        rif.start = 1'b0;
        case (st_ff.state)
            SSS_OFF: begin
                nxt_st.cnt = 32'h0;
                if (!fault && first_valid_i) begin
                    nxt_st.state = SSS_PRIMARY;
                    rif.start    = 1'b1;
                end else if (!fault && !first_high_i && second_valid_i) begin
                    nxt_st.state = SSS_SECOND;
                    rif.start    = 1'b1;
                end
            end
            SSS_PRIMARY: begin
                if (fault || (!first_valid_i && !first_high_i)) begin
                    nxt_st.state = SSS_OFF;
                end else if (first_high_i) begin
                    nxt_st.state = SSS_DETECT;
                    nxt_st.cnt   = 32'h0;
                end
            end
            SSS_DETECT, SSS_DRAIN: begin
                // Fixed wait stands in for the load-dependent discharge
                nxt_st.cnt = st_ff.cnt + 32'h1;
                if (fault) begin
                    nxt_st.state = SSS_OFF;
                end else if (!first_high_i) begin
                    nxt_st.state = SSS_OFF;
                end else if (!second_valid_i) begin
                    nxt_st.state = SSS_OPEN;
                end else if (st_ff.cnt >= 32'(DETECT_CYC + SWITCH_CYC - 1)) begin
                    nxt_st.state = SSS_SECOND;
                    rif.start    = 1'b1;
                end else if (st_ff.cnt >= 32'(DETECT_CYC - 1)) begin
                    nxt_st.state = SSS_DRAIN;
                end
            end
            SSS_SECOND: begin
                if (fault || !second_valid_i || first_valid_i) begin
                    nxt_st.state = SSS_OFF;
                end
            end
            SSS_OPEN: begin
                if (fault || !first_high_i || second_valid_i) begin
                    nxt_st.state = SSS_OFF;
                end
            end
            default: nxt_st.state = SSS_OFF;
        endcase
        sel_second     = nxt_st.state == SSS_SECOND;
        nxt_st.prim_on = nxt_st.state == SSS_PRIMARY;
        // Secondary output follows its enable in PRIMARY, and in SECOND only while first_high_i is set; first supply wins
        nxt_st.sec_on  = (nxt_st.prim_on && secondary_enable_i)
                      || (sel_second && first_high_i
                          && secondary_enable_i);
        // Newly enabled secondary output ramps from high resistance
        if (nxt_st.sec_on && !st_ff.sec_on) begin
            rif.start = 1'b1;
        end
        nxt_st.valid   = nxt_st.sec_on;
        // Buffers live on the output rail fed in SSS_PRIMARY or SSS_SECOND
        if (!(nxt_st.prim_on || sel_second) || !nxt_st.valid) begin
            nxt_st.tx_oe = 1'b0;
            nxt_st.tx    = 1'b0;
        end else begin
            nxt_st.tx_oe = output_enable_i;
            nxt_st.tx    = output_enable_i & cable_transmit_in_i;
        end
        nxt_st.rx = (nxt_st.prim_on || sel_second)
                  & host_receive_in_i;
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            st_ff <= '{state: SSS_OFF, cnt: 32'h0, default: 1'b0};
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    assign primary_pass_switches_o    = st_ff.state == SSS_PRIMARY;
    assign second_pass_switches_o     = st_ff.state == SSS_SECOND;
    assign primary_output_on_o        = st_ff.prim_on;
    assign secondary_output_on_o      = st_ff.sec_on;
    assign soft_step_o                = rif.step;
    assign output_valid_n_indicator_o = st_ff.valid;
    assign host_transmit_out_o        = st_ff.tx;
    assign host_transmit_out_oe_o     = st_ff.tx_oe;
    assign cable_receive_out_o        = st_ff.rx;

    hv_open_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && st_ff.state == SSS_PRIMARY && first_high_i && !fault
        |=> !primary_pass_switches_o)
        else $error("primary switches stayed closed in over-voltage");
    no_second_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && !second_valid_i |=> !second_pass_switches_o
            || !$past(ce_i))
        else $error("closed onto invalid second supply");
    tx_float_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        !output_valid_n_indicator_o |-> !host_transmit_out_oe_o)
        else $error("host transmit driven while indicator low");
    tx_follow_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && nxt_st.valid && output_enable_i |=> host_transmit_out_oe_o)
        else $error("enable pin ignored while indicator high");
    tx_data_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        host_transmit_out_oe_o |-> host_transmit_out_o == $past(cable_transmit_in_i)
            || !$past(ce_i))
        else $error("host transmit level wrong");
    rx_pass_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && st_ff.prim_on && nxt_st.prim_on |=> cable_receive_out_o
            == $past(host_receive_in_i))
        else $error("receive buffer not following");
    thermal_off_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        ce_i && fault |=> !primary_output_on_o)
        else $error("primary output on in thermal shutdown");
    valid_ind_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        output_valid_n_indicator_o |-> secondary_output_on_o)
        else $error("indicator high without secondary output");
    drain_wait_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
        st_ff.state == SSS_DETECT && ce_i |=> !second_pass_switches_o)
        else $error("closed onto second supply without drain");
endmodule : sss_top
`default_nettype wire

// File: dv/sss_uart_peer.sv
// Host UART and cable transceiver levels seen by the block
`timescale 1ns/1ps
`default_nettype none
module sss_uart_peer (
    // Clock
    input  wire logic clock_i,
    // Host transmit pin from the block
    input  wire logic tx_i,
    input  wire logic tx_oe_i,
    // Far side levels
    output logic      cable_tx_o,
    output logic      host_rx_o,
    output logic      oe_o,
    output logic      tx_wire_o
);
    int   seed = 46648;
    logic last = 1'b0;
    initial begin
        {cable_tx_o, host_rx_o, oe_o} = 3'h0;
    end
    // New random levels every falling edge, so stale data matches only by luck
    always @(negedge clock_i) begin
        {cable_tx_o, host_rx_o, oe_o} <= 3'($random(seed));
    end
    // Released pin has no pull: show the inverse of its last level
    always @(posedge clock_i) begin
        if (tx_oe_i) last <= tx_i;
    end
    assign tx_wire_o = tx_oe_i ? tx_i : ~last;
endmodule : sss_uart_peer
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the supply switch sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sss_pkg::*;
    localparam int STEP = 4;
    localparam int DET  = 3;
    localparam int SW   = 3;
    typedef struct {int id; logic [2:0] exp;} sss_note_t;
    logic       clock_i = 1'b0;
    logic       nrst_i  = 1'b0;
    logic       ce      = 1'b1;
    logic       fv = 1'b0, fh = 1'b0, sv = 1'b0, ts = 1'b0, se = 1'b0;
    logic       ctx, hrx, oe, psw, ssw, pon, son, vind, tx, txoe, crx, txw;
    logic [2:0] step;
    int         miscompares = 0;
    int         cmp_count   = 0;
    sss_note_t  q[$];
    sss_note_t  n;
    event       chk;
    string      nm[9] = '{"psw", "ssw", "pon", "vind", "txoe", "txw",
                          "crx", "step", "son"};
    always #10 clock_i = ~clock_i;
    sss_top #(.STEP_CYC(STEP), .DETECT_CYC(DET), .SWITCH_CYC(SW)) u_sss_top (
        .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce),
        .first_valid_i(fv), .first_high_i(fh), .second_valid_i(sv),
        .thermal_shutdown_i(ts), .secondary_enable_i(se),
        .primary_pass_switches_o(psw), .second_pass_switches_o(ssw),
        .primary_output_on_o(pon), .secondary_output_on_o(son),
        .soft_step_o(step), .output_valid_n_indicator_o(vind),
        .output_enable_i(oe), .cable_transmit_in_i(ctx),
        .host_receive_in_i(hrx), .host_transmit_out_o(tx),
        .host_transmit_out_oe_o(txoe), .cable_receive_out_o(crx));
    sss_uart_peer u_sss_uart_peer (
        .clock_i(clock_i), .tx_i(tx), .tx_oe_i(txoe), .cable_tx_o(ctx),
        .host_rx_o(hrx), .oe_o(oe), .tx_wire_o(txw));
    function automatic logic [2:0] obs(input int id);
        logic [7:0] b;
        b = {1'b0, crx, txw, txoe, vind, pon, ssw, psw};
        if (id == 8) return {2'h0, son};
        return (id == 7) ? step : {2'h0, b[id]};
    endfunction : obs
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic check(input logic [2:0] seen, input logic [2:0] exp,
                         input int id);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm[id], exp, seen);
        end
    endtask : check
    task automatic expect_val(input int id, input logic [2:0] exp);
        q.push_back('{id, exp});
        ->chk;
    endtask : expect_val
    // Results are compared as they are settled at the falling edge
    always @(chk) begin
        while (q.size() > 0) begin
            n = q.pop_front();
            check(obs(n.id), n.exp, n.id);
        end
    end
    task automatic wait_for(input int id, input logic [2:0] exp, input int lim);
        int k;
        k = 0;
        while (obs(id) !== exp && k < lim) begin
            @(negedge clock_i);
            k++;
        end
        expect_val(id, exp);
        // Timeout counts here; the watcher has not run before the end
        if (obs(id) !== exp) begin
            miscompares++;
            final_report();
        end
    endtask : wait_for
    // Levels read before the peer updates are those the block sampled
    task automatic uart_run(input logic v, input logic p);
        for (int i = 0; i < 16; i++) begin
            @(negedge clock_i);
            expect_val(4, {2'h0, oe & v});
            if (oe & v) expect_val(5, {2'h0, ctx});
            expect_val(6, {2'h0, hrx & p});
        end
    endtask : uart_run
    initial begin
        repeat (20) @(negedge clock_i);
        expect_val(7, 3'h4);
        expect_val(0, 3'h0);
        nrst_i = 1'b1;
        uart_run(1'b0, 1'b0);
        $display("done: reset and unpowered");
        fv = 1'b1;
        wait_for(7, 3'h0, 3);
        expect_val(0, 3'h1);
        ce = 1'b0;
        repeat (STEP + 2) @(negedge clock_i);
        expect_val(7, 3'h0);
        ce = 1'b1;
        for (int s = 1; s <= 4; s++) wait_for(7, 3'(s), STEP + 1);
        uart_run(1'b0, 1'b1);
        $display("done: soft start");
        se = 1'b1;
        wait_for(7, 3'h0, 4);
        wait_for(7, 3'h4, 4 * STEP + 4);
        wait_for(3, 3'h1, 8);
        expect_val(8, 3'h1);
        uart_run(1'b1, 1'b1);
        $display("done: uart buffers");
        sv = 1'b1;
        fv = 1'b0;
        fh = 1'b1;
        wait_for(0, 3'h0, 2);
        repeat (DET) @(negedge clock_i);
        expect_val(1, 3'h0);
        wait_for(1, 3'h1, SW + 3);
        fh = 1'b0;
        fv = 1'b1;
        wait_for(0, 3'h1, 6);
        expect_val(1, 3'h0);
        sv = 1'b0;
        fv = 1'b0;
        fh = 1'b1;
        repeat (DET + SW + 4) @(negedge clock_i);
        expect_val(0, 3'h0);
        expect_val(1, 3'h0);
        fh = 1'b0;
        fv = 1'b1;
        wait_for(0, 3'h1, 6);
        $display("done: over-voltage switch-over");
        ts = 1'b1;
        wait_for(2, 3'h0, 4);
        uart_run(1'b0, 1'b0);
        ts = 1'b0;
        wait_for(2, 3'h1, 8);
        fv = 1'b0;
        wait_for(2, 3'h0, 4);
        $display("done: shutdown");
        @(negedge clock_i);
        final_report();
    end
endmodule : tb
`default_nettype wire
